// ===== dv/lbbt_bridge_model.sv
// Bus master model standing in for the bridge
`timescale 1ns/100ps
module lbbt_bridge_model (
	input  wire logic        sys_clk,
	input  wire logic        ready_n,
	input  wire logic        oe,
	input  wire logic [31:0] rd_bus,
	output logic      [31:0] ad,
	output logic             strobe_n,
	output logic             wnr,
	output logic             last_n
);
	int cyc;
	// Idle master keeps strobe and burst-last high
	initial begin
		ad = 32'h0;
		strobe_n = 1'b1;
		wnr = 1'b0;
		last_n = 1'b1;
	end
	// One transfer of n words, entered just after an edge
	task automatic xfer(input logic w, input logic [31:0] a, input int n,
		input logic [31:0] d, output logic [31:0] rd);
		strobe_n = 1'b0;
		wnr = w;
		ad = a;
		@(posedge sys_clk);
		#1;
		strobe_n = 1'b1;
		cyc = 1;
		for (int i = 0; i < n; i++) begin
			ad = w ? d + 32'(i) : ~ad; // No stale value on reads
			last_n = (i == n - 1) ? 1'b0 : 1'b1;
			@(posedge sys_clk);
			cyc++;
			// A slow target is waited for, but not forever
			while (ready_n !== 1'b0 && cyc < 9) begin
				@(posedge sys_clk);
				cyc++;
			end
			// Any word off the bus or unlike the first poisons the result
			rd = (oe === 1'b1 && (i == 0 || rd_bus === rd)) ? rd_bus : 'x;
			#1;
		end
		last_n = 1'b1;
		ad = ~ad;
		// One idle cycle, so a following call never redrives in this step
		@(posedge sys_clk);
		#1;
	endtask
endmodule

// ===== dv/lbbt_target_bench.sv
// Self-checking bench for the local bus burst target
`timescale 1ns/100ps
`include "lbbt_defines.svh"
module lbbt_target_bench;
	logic        sys_clk, reset_n, irq_event, hold_req, oe, strobe_n, wnr;
	logic        last_n, grant, ready_n, term_n, irq_n;
	logic [7:0]  header;
	logic [31:0] ad, rd_bus, rd;
	int          fail_count, samples_checked;

	lbbt_target u_lbbt_target (.sys_clk(sys_clk), .reset_n(reset_n),
		.muxed_addr_data_in(ad), .muxed_addr_data_out(rd_bus),
		.muxed_addr_data_oe(oe), .address_strobe_n(strobe_n),
		.write_not_read(wnr), .burst_last_n(last_n),
		.bus_hold_request(hold_req), .bus_hold_grant(grant),
		.ready_n(ready_n), .burst_terminate_n(term_n),
		.irq_event(irq_event), .local_interrupt_n(irq_n),
		.probe_header(header));
	lbbt_bridge_model u_lbbt_bridge_model (.sys_clk(sys_clk),
		.ready_n(ready_n), .oe(oe), .rd_bus(rd_bus), .ad(ad),
		.strobe_n(strobe_n), .wnr(wnr), .last_n(last_n));
	// Free-running 100 ns clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// One compare kind; a mismatch prints a single ERROR line
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Transfer through the master, then check its length in cycles
	task automatic bus(input logic w, input logic [31:0] a, input int n,
		input logic [31:0] d);
		u_lbbt_bridge_model.xfer(w, a, n, d, rd);
		chk(32'(u_lbbt_bridge_model.cyc), 32'(n + 1));
	endtask
	task automatic t_reset;
		chk({27'h0, ready_n, oe, irq_n, term_n, grant}, 32'h16);
		chk({24'h0, header}, 32'h0);
	endtask
	task automatic t_single;
		bus(1'b1, 32'h100, 1, 32'h5A5A1234);
		bus(1'b0, 32'h100, 1, 32'h0);
		chk(rd, 32'h5A5A1234);
	endtask
	// Back-to-back bursts; the bus is let go afterwards
	task automatic t_burst;
		bus(1'b1, 32'h200, 3, 32'hC0DE0000);
		bus(1'b0, 32'h200, 4, 32'h0);
		chk(rd, 32'hC0DE0002);
		chk({30'h0, oe, term_n}, 32'h1);
	endtask
	// A write elsewhere must not clear the pending interrupt
	task automatic t_irq;
		irq_event = 1'b1;
		@(posedge sys_clk);
		#1;
		irq_event = 1'b0;
		@(posedge sys_clk);
		#1;
		chk({31'h0, irq_n}, 32'h0);
		bus(1'b1, 32'h0FF8, 1, 32'h1);
		chk({31'h0, irq_n}, 32'h0);
		bus(1'b1, `LBBT_ACK_ADDR, 1, 32'h2);
		@(posedge sys_clk);
		#1;
		chk({31'h0, irq_n}, 32'h1);
	endtask
	// Grant follows request both ways; idle header bits and clock toggle
	task automatic t_hold;
		logic tog;
		hold_req = 1'b1;
		@(posedge sys_clk);
		#1;
		chk({31'h0, grant}, 32'h1);
		@(posedge sys_clk);
		#1;
		chk({24'h0, header[7:2], 1'b0, header[0]}, 32'hFD);
		tog = header[1];
		hold_req = 1'b0;
		@(posedge sys_clk);
		#1;
		chk({31'h0, header[1]}, {31'h0, ~tog});
		chk({31'h0, grant}, 32'h0);
	endtask
	// Main sequence: reset for 12 cycles, then the scenarios
	initial begin
		fail_count = 0;
		samples_checked = 0;
		reset_n = 1'b0;
		irq_event = 1'b0;
		hold_req = 1'b0;
		repeat (12) @(posedge sys_clk);
		#1;
		t_reset;
		reset_n = 1'b1;
		t_single;
		t_burst;
		t_irq;
		t_hold;
		give_verdict;
	end
	// Watchdog: the scenarios need well under 2000 cycles
	initial begin
		#200000;
		fail_count++;
		give_verdict;
	end
endmodule

// ===== rtl/lbbt_defines.svh
// Constants for the local bus burst target
`ifndef LBBT_DEFINES_SVH
`define LBBT_DEFINES_SVH
`define LBBT_DATA_W      32
`define LBBT_DATA_RESET  32'h00000000
`define LBBT_ACK_ADDR    32'h00000FFC
`define LBBT_WAIT_CYCLES 2'h0
`define LBBT_TERM_EN     1'b0
`endif

// ===== rtl/lbbt_pkg.sv
// Types for the local bus burst target
package lbbt_pkg;
	typedef enum logic [1:0] {
		LBBT_IDLE,
		LBBT_WAIT,
		LBBT_DATA
	} lbbt_state_t;
endpackage

// ===== rtl/lbbt_target.sv
// Local bus target: single and burst transfers, held word, interrupt
// Function
// - Hold the interrupt output low while an interrupt is pending.
// - Release the interrupt output only after the acknowledge write is seen.
// - Accept single and burst transfers for reads and writes.
// - Ready may be held high to insert wait states in any transfer.
// - Burst-terminate stays high: even with the option on, a data phase without take never occurs.
// - Capture and hold the most recent written data word.
// - Complete transfers with the fewest wait states possible.
// - Copy the handshake signals to the observation header.
// - Drive ready low when write data is taken or read data is valid.
// - Drive read data only while ready is low, else release the bus.
// - Loop hold request back onto hold grant.
`timescale 1ns/100ps
`include "lbbt_defines.svh"
module lbbt_target
	import lbbt_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [31:0] muxed_addr_data_in,
	output logic      [31:0] muxed_addr_data_out,
	output logic             muxed_addr_data_oe,
	input  wire logic        address_strobe_n,
	input  wire logic        write_not_read,
	input  wire logic        burst_last_n,
	input  wire logic        bus_hold_request,
	output logic             bus_hold_grant,
	output logic             ready_n,
	output logic             burst_terminate_n,
	input  wire logic        irq_event,
	output logic             local_interrupt_n,
	output logic      [7:0]  probe_header
);

	lbbt_state_t             state_q;
	logic                    dir_write_q;
	logic                    ack_hit_q;
	logic        [1:0]       wait_q;
	logic [`LBBT_DATA_W-1:0] held_q;
	logic                    irq_pend_q;
	logic                    take;
	logic                    data_phase;

	// Data phase completes on every cycle ready is low
	assign take       = (state_q == LBBT_DATA) && !ready_n;
	assign data_phase = (state_q == LBBT_DATA);

	// Transfer sequencer
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= LBBT_IDLE;
			dir_write_q <= 1'b0;
			ack_hit_q   <= 1'b0;
			wait_q      <= 2'h0;
		end else begin
			case (state_q)
				LBBT_IDLE: begin
					if (!address_strobe_n) begin
						dir_write_q <= write_not_read;
						ack_hit_q   <= (muxed_addr_data_in == `LBBT_ACK_ADDR);
						wait_q      <= `LBBT_WAIT_CYCLES;
						state_q     <= (`LBBT_WAIT_CYCLES == 2'h0) ?
						               LBBT_DATA : LBBT_WAIT;
					end
				end
				LBBT_WAIT: begin
					wait_q <= wait_q - 2'h1;
					if (wait_q == 2'h1)
						state_q <= LBBT_DATA;
				end
				// burst ends on burst-last data phase
				LBBT_DATA: begin
					if (take && (!burst_last_n || !burst_terminate_n))
						state_q <= LBBT_IDLE;
				end
				default: state_q <= LBBT_IDLE;
			endcase
		end
	end

	// ready low through each data phase, one word per cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			ready_n <= 1'b1;
		else if (take && !burst_last_n)
			ready_n <= 1'b1;
		else if (state_q == LBBT_DATA)
			ready_n <= 1'b0;
		else if (state_q == LBBT_IDLE && !address_strobe_n &&
		         `LBBT_WAIT_CYCLES == 2'h0)
			ready_n <= 1'b0;
		else if (state_q == LBBT_WAIT && wait_q == 2'h1)
			ready_n <= 1'b0;
		else
			ready_n <= 1'b1;
	end

	// terminate option, off by default since it costs throughput
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			burst_terminate_n <= 1'b1;
		else
			burst_terminate_n <= !(`LBBT_TERM_EN && data_phase &&
			                       !take);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			held_q <= `LBBT_DATA_RESET;
		else if (take && dir_write_q)
			held_q <= muxed_addr_data_in;
	end

	// drive held word only together with ready on reads
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			muxed_addr_data_out <= `LBBT_DATA_RESET;
			muxed_addr_data_oe  <= 1'b0;
		end else begin
			muxed_addr_data_out <= held_q;
			if (take && !burst_last_n)
				muxed_addr_data_oe <= 1'b0;
			else if (state_q == LBBT_IDLE)
				muxed_addr_data_oe <= !address_strobe_n && !write_not_read &&
				                      `LBBT_WAIT_CYCLES == 2'h0;
			else if (state_q == LBBT_WAIT)
				muxed_addr_data_oe <= !dir_write_q && wait_q == 2'h1;
			else
				muxed_addr_data_oe <= !dir_write_q;
		end
	end

	// pending until acknowledge write; a new event wins
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			irq_pend_q <= 1'b0;
		else if (irq_event)
			irq_pend_q <= 1'b1;
		else if (take && dir_write_q && ack_hit_q)
			irq_pend_q <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			local_interrupt_n <= 1'b1;
		else
			local_interrupt_n <= !irq_pend_q;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			bus_hold_grant <= 1'b0;
		else
			bus_hold_grant <= bus_hold_request;
	end

	// observation copies, one cycle late; clock copy is a toggle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			probe_header <= 8'h00;
		else
			probe_header <= {write_not_read, ready_n, burst_last_n,
			                 address_strobe_n, bus_hold_grant,
			                 bus_hold_request, ~probe_header[1], reset_n};
	end

	// bus driven only with ready asserted
	a_drive_ready: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		muxed_addr_data_oe |-> !ready_n)
		else $error("bus driven without ready");

	// pin stays low until an acknowledge write is taken
	a_irq_hold: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		(!local_interrupt_n && irq_pend_q && !(take && ack_hit_q &&
		 dir_write_q)) |=> !local_interrupt_n)
		else $error("interrupt released early");

	// event drives pin low two cycles later
	a_irq_raise: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		irq_event |-> ##2 !local_interrupt_n)
		else $error("interrupt not raised");

	a_write_hold: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		(take && dir_write_q) |=> held_q == $past(muxed_addr_data_in))
		else $error("write word not held");

	a_read_data: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		(muxed_addr_data_oe && !dir_write_q) |->
		muxed_addr_data_out == held_q)
		else $error("read word mismatch");

	a_burst_end: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		(take && !burst_last_n) |=> state_q == LBBT_IDLE && ready_n)
		else $error("burst did not end");

	// ready follows strobe by one cycle
	a_zero_wait: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		(state_q == LBBT_IDLE && !address_strobe_n) |=> !ready_n)
		else $error("extra wait state");

	// grant follows request, rising and falling alike
	a_hold_loop: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		1'b1 |=> bus_hold_grant == $past(bus_hold_request))
		else $error("grant does not follow request");

	a_probe_copy: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		1'b1 |=> probe_header[4] == $past(address_strobe_n))
		else $error("probe copy wrong");

	// every strobe gets a data phase
	a_accept_xfer: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		(state_q == LBBT_IDLE && !address_strobe_n) |-> ##[1:4] take)
		else $error("transfer not accepted");

	a_no_term: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		!`LBBT_TERM_EN |-> burst_terminate_n)
		else $error("unexpected terminate");

endmodule
